// ===== design/bcs_core.sv
// bit set/clear/swap and compare-skip execution unit with its accumulator, flags, port a and memory
`timescale 1ns/1ps
`default_nettype none
module bcs_core (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// instruction stream
	input wire logic i_valid,
	input wire bcs_pkg::bcs_instr_s i_instr,
	// port a pins
	input wire logic [bcs_pkg::DATA_W-1:0] i_port_a_pin,
	output logic [bcs_pkg::DATA_W-1:0] o_port_a_value,
	output logic [bcs_pkg::DATA_W-1:0] o_port_a_oe,
	// memory observation port
	input wire logic [bcs_pkg::ADDR_W-1:0] i_mem_raddr,
	output logic [bcs_pkg::DATA_W-1:0] o_mem_rdata,
	// core state
	output logic [bcs_pkg::DATA_W-1:0] o_accumulator,
	output logic [bcs_pkg::DATA_W-1:0] o_flags,
	output logic [bcs_pkg::PC_W-1:0] o_pc,
	output logic o_skip_pending,
	output logic o_skipped
);
	localparam int DW = bcs_pkg::DATA_W;

	function automatic logic [DW-1:0] bit_mask(input logic [bcs_pkg::BIT_W-1:0] idx);
		logic [DW-1:0] m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction : bit_mask

	function automatic logic [DW-1:0] sub_flags(input logic [DW-1:0] a, input logic [DW-1:0] b,
		input logic [DW-1:0] old);
		logic [DW:0] full;
		logic [bcs_pkg::NIBBLE_W:0] low;
		logic [DW-1:0] f;
		full = {1'b0, a} - {1'b0, b};
		low = {1'b0, a[bcs_pkg::NIBBLE_W-1:0]} - {1'b0, b[bcs_pkg::NIBBLE_W-1:0]};
		f = old;
		f[bcs_pkg::FLAG_Z] = (full[DW-1:0] == '0);
		f[bcs_pkg::FLAG_C] = full[DW];
		f[bcs_pkg::FLAG_AC] = low[bcs_pkg::NIBBLE_W];
		f[bcs_pkg::FLAG_OV] = (a[DW-1] ^ b[DW-1]) & (a[DW-1] ^ full[DW-1]);
		return f;
	endfunction : sub_flags

	logic [DW-1:0] acc_q;
	logic [DW-1:0] flag_q;
	logic [DW-1:0] port_q;
	logic [DW-1:0] dir_q;
	logic [DW-1:0] mem_q [bcs_pkg::MEM_DEPTH];
	logic [bcs_pkg::PC_W-1:0] pc_q;
	logic skip_q;
	logic skipped_q;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] sync1_q;
	logic [DW-1:0] sync2_q;
	logic [DW-1:0] sync3_q;
	logic [DW-1:0] pin_q;

	logic exec;
	logic [DW-1:0] mask;
	logic [DW-1:0] mem_byte;
	logic [DW-1:0] operand;
	logic is_cmp;
	logic is_eq_kind;
	logic equal;
	logic take_skip;
	logic io_bit;
	logic carry;

	// pin sampling: three stages, a bit counts once stages two and three agree
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_q <= bcs_pkg::PORT_RESET;
			sync2_q <= bcs_pkg::PORT_RESET;
			sync3_q <= bcs_pkg::PORT_RESET;
			pin_q <= bcs_pkg::PORT_RESET;
		end else begin
			sync1_q <= i_port_a_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));
		end
	end

	// decode of the current instruction
	assign exec = i_valid && !skip_q;
	assign mask = bit_mask(i_instr.bit_idx);
	assign mem_byte = mem_q[i_instr.addr];
	assign carry = flag_q[bcs_pkg::FLAG_C];
	assign is_cmp = (i_instr.op == bcs_pkg::OP_CMP_IMM_EQ) || (i_instr.op == bcs_pkg::OP_CMP_MEM_EQ)
		|| (i_instr.op == bcs_pkg::OP_CMP_MEM_NE) || (i_instr.op == bcs_pkg::OP_CMP_IMM_NE);
	assign is_eq_kind = (i_instr.op == bcs_pkg::OP_CMP_IMM_EQ)
		|| (i_instr.op == bcs_pkg::OP_CMP_MEM_EQ);
	assign operand = ((i_instr.op == bcs_pkg::OP_CMP_MEM_EQ)
		|| (i_instr.op == bcs_pkg::OP_CMP_MEM_NE)) ? mem_byte : i_instr.imm;
	assign equal = (acc_q == operand);
	assign take_skip = exec && is_cmp && (equal == is_eq_kind);

	// current value of the addressed i/o bit as the swap sees it
	always_comb begin
		case (i_instr.addr)
			bcs_pkg::IO_PORT_A: io_bit = |((dir_q[i_instr.bit_idx] ? port_q : pin_q) & mask);
			bcs_pkg::IO_PORT_A_DIR: io_bit = |(dir_q & mask);
			bcs_pkg::IO_FLAG: io_bit = |(flag_q & mask);
			default: io_bit = 1'b0;
		endcase
	end

	// accumulator: only the test load writes it, compares leave it alone
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_q <= bcs_pkg::ACC_RESET;
		end else if (exec && i_instr.op == bcs_pkg::OP_LOAD_ACC) begin
			acc_q <= i_instr.imm;
		end
	end

	// flag register, addressable as an i/o register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			flag_q <= bcs_pkg::FLAG_RESET;
		end else if (exec) begin
			case (i_instr.op)
				bcs_pkg::OP_IO_CLEAR: begin
					if (i_instr.addr == bcs_pkg::IO_FLAG) begin
						flag_q <= flag_q & ~mask;
					end
				end
				bcs_pkg::OP_IO_SET: begin
					if (i_instr.addr == bcs_pkg::IO_FLAG) begin
						flag_q <= flag_q | mask;
					end
				end
				bcs_pkg::OP_SWAP_CARRY: begin
					if (i_instr.addr != bcs_pkg::IO_FLAG || i_instr.bit_idx != bcs_pkg::FLAG_C) begin
						flag_q[bcs_pkg::FLAG_C] <= io_bit;
					end
				end
				bcs_pkg::OP_CMP_IMM_EQ, bcs_pkg::OP_CMP_MEM_EQ,
				bcs_pkg::OP_CMP_MEM_NE, bcs_pkg::OP_CMP_IMM_NE: begin
					flag_q <= sub_flags(acc_q, operand, flag_q);
				end
				default: begin
					flag_q <= flag_q;
				end
			endcase
		end
	end

	// port a data latch
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			port_q <= bcs_pkg::PORT_RESET;
		end else if (exec && i_instr.addr == bcs_pkg::IO_PORT_A) begin
			case (i_instr.op)
				bcs_pkg::OP_IO_CLEAR: port_q <= port_q & ~mask;
				bcs_pkg::OP_IO_SET: port_q <= port_q | mask;
				bcs_pkg::OP_SWAP_CARRY: port_q <= carry ? (port_q | mask) : (port_q & ~mask);
				default: port_q <= port_q;
			endcase
		end
	end

	// port a direction register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			dir_q <= bcs_pkg::DIR_RESET;
		end else if (exec && i_instr.addr == bcs_pkg::IO_PORT_A_DIR) begin
			case (i_instr.op)
				bcs_pkg::OP_IO_CLEAR: dir_q <= dir_q & ~mask;
				bcs_pkg::OP_IO_SET: dir_q <= dir_q | mask;
				bcs_pkg::OP_SWAP_CARRY: dir_q <= carry ? (dir_q | mask) : (dir_q & ~mask);
				default: dir_q <= dir_q;
			endcase
		end
	end

	// data memory, not reset
	always_ff @(posedge i_clock) begin
		if (exec) begin
			case (i_instr.op)
				bcs_pkg::OP_LOAD_MEM: mem_q[i_instr.addr] <= i_instr.imm;
				bcs_pkg::OP_MEM_CLEAR: mem_q[i_instr.addr] <= mem_byte & ~mask;
				bcs_pkg::OP_MEM_SET: mem_q[i_instr.addr] <= mem_byte | mask;
				default: mem_q[i_instr.addr] <= mem_byte;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= bcs_pkg::PORT_RESET;
		end else begin
			rdata_q <= mem_q[i_mem_raddr];
		end
	end

	// program counter steps for every fetched word, skipped or not
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_q <= bcs_pkg::PC_RESET;
		end else if (i_valid) begin
			pc_q <= pc_q + bcs_pkg::PC_STEP;
		end
	end

	// skip state: a skipped word cannot itself arm a new skip
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			skip_q <= 1'b0;
			skipped_q <= 1'b0;
		end else begin
			skipped_q <= i_valid && skip_q;
			if (take_skip) begin
				skip_q <= 1'b1;
			end else if (i_valid) begin
				skip_q <= 1'b0;
			end
		end
	end

	assign o_port_a_value = port_q;
	assign o_port_a_oe = dir_q;
	assign o_mem_rdata = rdata_q;
	assign o_accumulator = acc_q;
	assign o_flags = flag_q;
	assign o_pc = pc_q;
	assign o_skip_pending = skip_q;
	assign o_skipped = skipped_q;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	sequence issue_s(bcs_pkg::bcs_op_e op);
		exec && i_instr.op == op;
	endsequence

	sequence port_issue_s(bcs_pkg::bcs_op_e op);
		issue_s(op) ##0 (i_instr.addr == bcs_pkg::IO_PORT_A);
	endsequence

	io_bit_clear_a: assert property (port_issue_s(bcs_pkg::OP_IO_CLEAR) |=>
		o_port_a_value == ($past(o_port_a_value) & ~$past(mask)) && $stable(o_flags))
		else $error("i/o bit clear wrong");

	io_bit_set_a: assert property (port_issue_s(bcs_pkg::OP_IO_SET) |=>
		o_port_a_value == ($past(o_port_a_value) | $past(mask)) && $stable(o_flags))
		else $error("i/o bit set wrong");

	mem_bit_clear_a: assert property (issue_s(bcs_pkg::OP_MEM_CLEAR) |=>
		mem_q[$past(i_instr.addr)] == ($past(mem_byte) & ~$past(mask)) && $stable(o_flags))
		else $error("memory bit clear wrong");

	mem_bit_set_a: assert property (issue_s(bcs_pkg::OP_MEM_SET) |=>
		mem_q[$past(i_instr.addr)] == ($past(mem_byte) | $past(mask)) && $stable(o_flags))
		else $error("memory bit set wrong");

	swap_keeps_flags_a: assert property (issue_s(bcs_pkg::OP_SWAP_CARRY) |=>
		o_flags[bcs_pkg::FLAG_Z] == $past(o_flags[bcs_pkg::FLAG_Z])
		&& o_flags[bcs_pkg::FLAG_AC] == $past(o_flags[bcs_pkg::FLAG_AC])
		&& o_flags[bcs_pkg::FLAG_OV] == $past(o_flags[bcs_pkg::FLAG_OV]))
		else $error("swap touched a non-carry flag");

	swap_out_pin_a: assert property (port_issue_s(bcs_pkg::OP_SWAP_CARRY)
		##0 dir_q[i_instr.bit_idx] |=> |(o_port_a_value & $past(mask)) == $past(carry)
		&& o_flags[bcs_pkg::FLAG_C] == $past(|(port_q & mask)))
		else $error("swap to output pin wrong");

	swap_in_pin_a: assert property (port_issue_s(bcs_pkg::OP_SWAP_CARRY)
		##0 !dir_q[i_instr.bit_idx] |=> o_flags[bcs_pkg::FLAG_C] == $past(|(pin_q & mask)))
		else $error("swap from input pin wrong");

	carry_bit_set_a: assert property (issue_s(bcs_pkg::OP_IO_SET) ##0 (i_instr.addr ==
		bcs_pkg::IO_FLAG && i_instr.bit_idx == bcs_pkg::FLAG_C) |=> o_flags[bcs_pkg::FLAG_C])
		else $error("carry not set by flag bit 1");

	dir_oe_a: assert property (issue_s(bcs_pkg::OP_IO_CLEAR)
		##0 (i_instr.addr == bcs_pkg::IO_PORT_A_DIR) |=> !(|(o_port_a_oe & $past(mask))))
		else $error("direction clear left pin driven");

	cmp_skip_a: assert property (exec && is_cmp |=>
		o_skip_pending == ($past(acc_q == operand) == $past(is_eq_kind)))
		else $error("compare skip decision wrong");

	cmp_flags_a: assert property (exec && is_cmp |=> $stable(o_accumulator)
		&& o_flags[bcs_pkg::FLAG_C] == ($past(acc_q) < $past(operand))
		&& o_flags[bcs_pkg::FLAG_Z] == ($past(acc_q) == $past(operand)))
		else $error("compare flags or accumulator wrong");

	skipped_quiet_a: assert property (i_valid && skip_q |=> o_skipped && !o_skip_pending
		&& $stable(o_flags) && $stable(o_accumulator) && $stable(o_port_a_value)
		&& $stable(o_port_a_oe) && o_pc == $past(o_pc) + bcs_pkg::PC_STEP)
		else $error("skipped instruction had an effect");
endmodule : bcs_core
`default_nettype wire

// ===== design/bcs_pkg.sv
// package: opcodes, addresses, flag layout and instruction carrier for the bit/compare unit
package bcs_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 6;
	localparam int BIT_W = 3;
	localparam int MEM_DEPTH = 64;
	localparam int PC_W = 12;

	// i/o register addresses
	localparam logic [ADDR_W-1:0] IO_FLAG = 6'h00;
	localparam logic [ADDR_W-1:0] IO_PORT_A = 6'h10;
	localparam logic [ADDR_W-1:0] IO_PORT_A_DIR = 6'h11;

	// flag register bit positions
	localparam int FLAG_Z = 0;
	localparam int FLAG_C = 1;
	localparam int FLAG_AC = 2;
	localparam int FLAG_OV = 3;
	localparam int NIBBLE_W = 4;

	localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] PORT_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [PC_W-1:0] PC_STEP = 12'h001;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_LOAD_ACC,
		OP_LOAD_MEM,
		OP_IO_CLEAR,
		OP_IO_SET,
		OP_MEM_CLEAR,
		OP_MEM_SET,
		OP_SWAP_CARRY,
		OP_CMP_IMM_EQ,
		OP_CMP_MEM_EQ,
		OP_CMP_MEM_NE,
		OP_CMP_IMM_NE
	} bcs_op_e;

	typedef struct packed {
		bcs_op_e op;
		logic [BIT_W-1:0] bit_idx;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] imm;
	} bcs_instr_s;
endpackage : bcs_pkg

// ===== test/tb.sv
// self-checking testbench for the bit set/clear/swap and compare-skip unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clock;
	logic i_resetn;
	logic i_valid;
	bcs_pkg::bcs_instr_s i_instr;
	logic [7:0] i_port_a_pin;
	logic [5:0] i_mem_raddr;
	logic [7:0] o_port_a_value;
	logic [7:0] o_port_a_oe;
	logic [7:0] o_mem_rdata;
	logic [7:0] o_accumulator;
	logic [7:0] o_flags;
	logic [11:0] o_pc;
	logic o_skip_pending;
	logic o_skipped;
	int miscompares;
	int tests_run;

	bcs_core dut_u (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_valid(i_valid),
		.i_instr(i_instr),
		.i_port_a_pin(i_port_a_pin),
		.o_port_a_value(o_port_a_value),
		.o_port_a_oe(o_port_a_oe),
		.i_mem_raddr(i_mem_raddr),
		.o_mem_rdata(o_mem_rdata),
		.o_accumulator(o_accumulator),
		.o_flags(o_flags),
		.o_pc(o_pc),
		.o_skip_pending(o_skip_pending),
		.o_skipped(o_skipped)
	);

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// drives one word at a falling edge; valid stays up for back-to-back words
	task automatic issue(input bcs_pkg::bcs_op_e op, input logic [2:0] b, input logic [5:0] a,
			input logic [7:0] d);
		i_valid = 1'b1;
		i_instr = '{op: op, bit_idx: b, addr: a, imm: d};
		@(negedge i_clock);
	endtask : issue

	// drops valid and lets one edge pass so valid is never assigned twice in a step
	task automatic idle();
		i_valid = 1'b0;
		@(negedge i_clock);
	endtask : idle

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		i_mem_raddr = a;
		@(negedge i_clock);
		d = o_mem_rdata;
	endtask : rd

	task automatic t_io_bits();
		issue(bcs_pkg::OP_IO_SET, 3'h5, bcs_pkg::IO_PORT_A, 8'h00);
		issue(bcs_pkg::OP_IO_SET, 3'h0, bcs_pkg::IO_FLAG, 8'h00);
		issue(bcs_pkg::OP_IO_SET, 3'h5, bcs_pkg::IO_PORT_A_DIR, 8'h00);
		issue(bcs_pkg::OP_IO_SET, 3'h2, bcs_pkg::IO_PORT_A, 8'h00);
		issue(bcs_pkg::OP_IO_CLEAR, 3'h5, bcs_pkg::IO_PORT_A, 8'h00);
		idle();
		chk(o_port_a_value, 8'h04);
		chk(o_port_a_oe, 8'h20);
		chk(o_flags, 8'h01);
		issue(bcs_pkg::OP_IO_SET, 3'h1, bcs_pkg::IO_FLAG, 8'h00);
		idle();
		chk(o_flags, 8'h03);
		issue(bcs_pkg::OP_IO_CLEAR, 3'h1, bcs_pkg::IO_FLAG, 8'h00);
		idle();
		chk(o_flags, 8'h01);
	endtask : t_io_bits

	task automatic t_mem_bits();
		logic [7:0] d;
		issue(bcs_pkg::OP_LOAD_MEM, 3'h0, 6'h05, 8'hA5);
		issue(bcs_pkg::OP_MEM_SET, 3'h1, 6'h05, 8'h00);
		issue(bcs_pkg::OP_MEM_CLEAR, 3'h7, 6'h05, 8'h00);
		idle();
		rd(6'h05, d);
		chk(d, 8'h27);
		chk(o_flags, 8'h01);
	endtask : t_mem_bits

	task automatic t_swap();
		// output pin: latch bit 2 low, carry high, then exchange
		issue(bcs_pkg::OP_IO_SET, 3'h2, bcs_pkg::IO_PORT_A_DIR, 8'h00);
		issue(bcs_pkg::OP_IO_CLEAR, 3'h2, bcs_pkg::IO_PORT_A, 8'h00);
		issue(bcs_pkg::OP_IO_SET, 3'h1, bcs_pkg::IO_FLAG, 8'h00);
		issue(bcs_pkg::OP_SWAP_CARRY, 3'h2, bcs_pkg::IO_PORT_A, 8'h00);
		idle();
		chk(o_port_a_value[2], 1'b1);
		chk(o_port_a_oe, 8'h24);
		chk(o_flags, 8'h01);
		// input pin: carry low, pin bit 3 high and settled through the sampler
		i_port_a_pin = 8'h08;
		repeat (4) @(negedge i_clock);
		issue(bcs_pkg::OP_SWAP_CARRY, 3'h3, bcs_pkg::IO_PORT_A, 8'h00);
		idle();
		chk(o_flags, 8'h03);
		chk(o_port_a_oe[3], 1'b0);
		// exchange with direction bit 0: carry goes low, bit 0 becomes output
		issue(bcs_pkg::OP_SWAP_CARRY, 3'h0, bcs_pkg::IO_PORT_A_DIR, 8'h00);
		idle();
		chk(o_port_a_oe, 8'h25);
		chk(o_flags, 8'h01);
	endtask : t_swap

	task automatic t_compare();
		bcs_pkg::bcs_op_e ops[4];
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] r;
		logic [7:0] fl;
		logic [11:0] pc0;
		logic skip;
		logic is_eq_op;
		ops = '{bcs_pkg::OP_CMP_IMM_EQ, bcs_pkg::OP_CMP_MEM_EQ, bcs_pkg::OP_CMP_MEM_NE,
			bcs_pkg::OP_CMP_IMM_NE};
		a = 8'h35;
		for (int i = 0; i < 4; i++) begin
			for (int e = 0; e < 2; e++) begin
				b = (e != 0) ? a : 8'h8C;
				is_eq_op = (i < 2);
				skip = is_eq_op ? (a == b) : (a != b);
				r = a - b;
				issue(bcs_pkg::OP_LOAD_ACC, 3'h0, 6'h00, a);
				issue(bcs_pkg::OP_LOAD_MEM, 3'h0, 6'h09, b);
				idle();
				fl = o_flags;
				pc0 = o_pc;
				issue(ops[i], 3'h0, 6'h09, b);
				idle();
				chk(o_flags, {fl[7:4], (a[7] != b[7]) && (r[7] != a[7]), a[3:0] < b[3:0],
					a < b, r == 8'h00});
				chk(o_accumulator, a);
				chk(o_skip_pending, skip);
				issue(bcs_pkg::OP_LOAD_ACC, 3'h0, 6'h00, 8'hEE);
				chk(o_skipped, skip);
				chk(o_accumulator, skip ? a : 8'hEE);
				issue(bcs_pkg::OP_LOAD_ACC, 3'h0, 6'h00, 8'h5A);
				chk(o_skipped, 1'b0);
				idle();
				chk(o_accumulator, 8'h5A);
				chk(o_pc, pc0 + 12'h003);
				chk(o_skip_pending, 1'b0);
			end
		end
	endtask : t_compare

	task automatic t_skip_effect();
		logic [7:0] d;
		// an equal compare, then a gap, then a memory write that must vanish
		issue(bcs_pkg::OP_LOAD_ACC, 3'h0, 6'h00, 8'h10);
		issue(bcs_pkg::OP_CMP_IMM_EQ, 3'h0, 6'h00, 8'h10);
		idle();
		@(negedge i_clock);
		chk(o_skip_pending, 1'b1);
		issue(bcs_pkg::OP_LOAD_MEM, 3'h0, 6'h05, 8'hFF);
		chk(o_skipped, 1'b1);
		idle();
		rd(6'h05, d);
		chk(d, 8'h27);
		chk(o_skipped, 1'b0);
	endtask : t_skip_effect

	initial begin
		miscompares = 0;
		tests_run = 0;
		i_resetn = 1'b0;
		i_valid = 1'b0;
		i_instr = '0;
		i_port_a_pin = 8'h00;
		i_mem_raddr = 6'h00;
		repeat (8) @(negedge i_clock);
		i_resetn = 1'b1;
		@(negedge i_clock);
		chk(o_flags, bcs_pkg::FLAG_RESET);
		chk(o_pc, bcs_pkg::PC_RESET);
		t_io_bits();
		t_mem_bits();
		t_swap();
		t_compare();
		t_skip_effect();
		final_report();
	end

	// cuts a hang short well past the roughly 110 cycles the tests need
	initial begin
		#100000;
		miscompares++;
		final_report();
	end
endmodule : tb
`default_nettype wire
